// ---- core/dqd_pkg.sv ----
// package: constants, carriers and states of the descriptor queue dma
package dqd_pkg;
	// -------------------------------------------------------------
	// widths and queue indices
	// -------------------------------------------------------------
	localparam int DQD_AW   = 28;
	localparam int Q_TXREQ  = 0;
	localparam int Q_CONF   = 1;
	localparam int Q_POOL   = 2;
	localparam int Q_IND    = 3;
	// -------------------------------------------------------------
	// register offsets (byte addresses)
	// -------------------------------------------------------------
	localparam logic [3:0] OFF_QBASE = 4'h0;
	localparam logic [3:0] OFF_QLIM  = 4'h4;
	localparam logic [3:0] OFF_QPTR  = 4'h8;
	localparam logic [7:0] OFF_CTRL  = 8'h40;
	localparam logic [7:0] OFF_STAT  = 8'h44;
	// -------------------------------------------------------------
	// field positions, sizes, reset values
	// -------------------------------------------------------------
	localparam int         RQ_FIRST  = 31;
	localparam int         RQ_LAST   = 30;
	localparam int         CK_LAST   = 31;
	localparam int         D_VALID   = 31;
	localparam int         QB_BIG    = 31;
	localparam int         CT_EN     = 0;
	localparam int         CT_FPB    = 1;
	localparam logic [1:0] CLS_TEND  = 2'h1;
	localparam logic [11:0] DESC_B   = 12'h008;
	localparam logic [27:0] PAGE_SEL = 28'hffff000;
	localparam logic [1:0] CTRL_RST  = 2'h0;
	// -------------------------------------------------------------
	// carriers and states
	// -------------------------------------------------------------
	typedef struct packed {
		logic [27:0] base;
		logic        big;
		logic [11:0] lim;
	} dqd_qcfg_t;
	localparam dqd_qcfg_t QCFG_RST = '0;
	typedef struct packed {
		logic [31:0] data;
		logic        last;
	} dqd_rxw_t;
	typedef enum {ST_IDLE, ST_RQ0, ST_RQ1, ST_CD0, ST_CD1, ST_TXRD, ST_TXOUT,
		ST_CF0, ST_CF1, ST_PSP, ST_RXWR, ST_ID0, ST_ID1} dqd_state_t;
endpackage

// ---- core/dqd_dma.sv ----
// descriptor queue dma: receive fifo and the queue engine with its registers
//
// Contract
// - each queue stays inside its own aligned 1 kb or 4 kb region.
// - chunk descriptor arrays start 8-byte aligned; their counter wraps at 4 kb.
// - receive data never goes past the next 4 kb boundary of a buffer.
// - chunks take any byte alignment; the fetch counter wraps at 4 kb.
// - transmit-end class writes one confirm carrying the first descriptor's tag.
// - request queue pointer moves past every consumed descriptor.
// - limit writes are seen at once and never missed.
// - confirm and indicate descriptors go out as two single-word grants, word0 first.
// - without frame-per-buffer mode frames pack into one buffer.
// - indicate word1 holds the frame data address; masking gives its page.
//
// The register addresses and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
module dqd_fifo #(
	parameter int W     = 33,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// fill side
	input  wire logic [W-1:0] in_data_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	// drain side
	output logic [W-1:0]      out_data_o,
	output logic              out_valid_o,
	input  wire logic         out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW:0]  wp, rp, next_wp, next_rp;

	// full when pointers differ only in the wrap bit
	assign in_ready_o  = !(wp[AW] != rp[AW] && wp[AW-1:0] == rp[AW-1:0]);
	assign out_valid_o = wp != rp;
	assign out_data_o  = mem[rp[AW-1:0]];

	always_comb begin
		next_wp = wp + (AW+1)'(in_valid_i && in_ready_o);
		next_rp = rp + (AW+1)'(out_valid_o && out_ready_i);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wp <= '0;
			rp <= '0;
		end else begin
			wp <= next_wp;
			rp <= next_rp;
		end
		if (in_valid_i && in_ready_o) begin
			mem[wp[AW-1:0]] <= in_data_i;
		end
	end
endmodule

module dqd_dma #(
	parameter int FIFO_DEPTH = 8
) (
	// clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// wishbone register slave
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [7:0]        wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic [31:0]            wb_dat_o,
	output logic                   wb_ack_o,
	// shared memory bus, one word per grant
	output logic                   mem_req_o,
	input  wire logic              mem_gnt_i,
	output logic                   mem_we_o,
	output logic [dqd_pkg::DQD_AW-1:0] mem_adr_o,
	output logic [31:0]            mem_dat_o,
	input  wire logic [31:0]       mem_dat_i,
	// transmit byte stream
	output logic [7:0]             tx_byte_o,
	output logic                   tx_valid_o,
	output logic                   tx_last_o,
	input  wire logic              tx_ready_i,
	// receive word stream
	input  wire dqd_pkg::dqd_rxw_t rx_word_i,
	input  wire logic              rx_valid_i,
	output logic                   rx_ready_o
);
	import dqd_pkg::*;

	function automatic logic [27:0] q_adr(dqd_qcfg_t c, logic [11:0] p);
		q_adr = c.big ? {c.base[27:12], p} : {c.base[27:10], p[9:0]};
	endfunction
	function automatic logic [11:0] q_inc(dqd_qcfg_t c, logic [11:0] p);
		q_inc = c.big ? p + DESC_B : {2'h0, p[9:0] + DESC_B[9:0]};
	endfunction
	function automatic logic [27:0] pg_inc(logic [27:0] a, logic [11:0] n);
		pg_inc = {a[27:12], a[11:0] + n};
	endfunction
	function automatic logic [31:0] wb_merge(logic [31:0] o, logic [31:0] d, logic [3:0] s);
		wb_merge = o;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				wb_merge[8*b +: 8] = d[8*b +: 8];
			end
		end
	endfunction

	// -------------------------------------------------------------
	// register file
	// -------------------------------------------------------------
	dqd_qcfg_t       cfg [4];
	logic [11:0]     qptr [4];
	logic [1:0]      ctrl, next_ctrl;
	logic [31:0]     next_rd;
	logic            wb_wr, wb_acc, buf_ok;
	dqd_state_t      state;

	assign wb_acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wb_wr  = wb_acc && wb_we_i;

	// per queue base and limit; the engine reads them live every cycle
	for (genvar q = 0; q < 4; q++) begin : g_q
		dqd_qcfg_t   nxt;
		logic [31:0] t;
		always_comb begin
			nxt = cfg[q];
			t   = '0;
			if (wb_wr && wb_adr_i[7:6] == 2'h0 && wb_adr_i[5:4] == 2'(q)) begin
				if (wb_adr_i[3:0] == OFF_QBASE) begin
					t = wb_merge({cfg[q].big, 3'h0, cfg[q].base}, wb_dat_i, wb_sel_i);
					nxt.base = t[27:0];
					nxt.big  = t[QB_BIG];
				end else if (wb_adr_i[3:0] == OFF_QLIM) begin
					t = wb_merge({20'h0, cfg[q].lim}, wb_dat_i, wb_sel_i);
					nxt.lim = t[11:0];
				end
			end
		end
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				cfg[q] <= QCFG_RST;
			end else begin
				cfg[q] <= nxt;
			end
		end
	end

	// control, read mux; unmapped reads give zero, writes are dropped
	always_comb begin
		next_ctrl = ctrl;
		next_rd   = '0;
		if (wb_wr && wb_adr_i == OFF_CTRL) begin
			next_ctrl = 2'(wb_merge({30'h0, ctrl}, wb_dat_i, wb_sel_i));
		end
		if (wb_adr_i[7:6] == 2'h0) begin
			case (wb_adr_i[3:0])
				OFF_QBASE: next_rd = {cfg[wb_adr_i[5:4]].big, 3'h0, cfg[wb_adr_i[5:4]].base};
				OFF_QLIM:  next_rd = {20'h0, cfg[wb_adr_i[5:4]].lim};
				OFF_QPTR:  next_rd = {20'h0, qptr[wb_adr_i[5:4]]};
				default:   next_rd = '0;
			endcase
		end else if (wb_adr_i == OFF_CTRL) begin
			next_rd = {30'h0, ctrl};
		end else if (wb_adr_i == OFF_STAT) begin
			next_rd = {26'h0, buf_ok, tx_valid_o, 4'(state)};
		end
	end

	// every access answers one cycle later, ack drops the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl     <= CTRL_RST;
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			ctrl     <= next_ctrl;
			wb_ack_o <= wb_acc;
			wb_dat_o <= wb_acc && !wb_we_i ? next_rd : wb_dat_o;
		end
	end

	// -------------------------------------------------------------
	// receive fifo, back-pressure reaches rx_ready_o
	// -------------------------------------------------------------
	dqd_rxw_t rxf;
	logic     rxf_valid, rxf_pop;

	dqd_fifo #(.W($bits(dqd_rxw_t)), .DEPTH(FIFO_DEPTH)) u_rxf (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.in_data_i   (rx_word_i),
		.in_valid_i  (rx_valid_i),
		.in_ready_o  (rx_ready_o),
		.out_data_o  (rxf),
		.out_valid_o (rxf_valid),
		.out_ready_i (rxf_pop)
	);

	// -------------------------------------------------------------
	// queue engine
	// -------------------------------------------------------------
	dqd_state_t  next_state;
	logic [11:0] next_qptr [4];
	logic [31:0] rq_w0, next_rq_w0, word, next_word;
	logic [15:0] tag, next_tag;
	logic [1:0]  cls, next_cls;
	logic [27:0] cd_adr, next_cd_adr, ck_adr, next_ck_adr;
	logic [27:0] rx_adr, next_rx_adr, rx_start, next_rx_start;
	logic [12:0] ck_len, next_ck_len, rx_cnt, next_rx_cnt;
	logic        ck_last, next_ck_last, fr_end, next_fr_end, next_buf_ok;
	logic        gap, done, mem_st, go, chunk_end, rq_adv;
	logic [7:0]  next_tx_byte;
	logic        next_tx_valid, next_tx_last;

	assign mem_st = state != ST_IDLE && state != ST_TXOUT;
	assign done   = mem_req_o && mem_gnt_i;
	assign rxf_pop = state == ST_RXWR && done;

	// request gating: producer queues need granted space; gap splits grants
	always_comb begin
		case (state)
			ST_CF0:  go = qptr[Q_CONF] != cfg[Q_CONF].lim;
			ST_ID0:  go = qptr[Q_IND] != cfg[Q_IND].lim;
			ST_RXWR: go = rxf_valid;
			default: go = 1'b1;
		endcase
		mem_req_o = mem_st && !gap && go;
	end

	// address and data of the word in flight
	always_comb begin
		mem_we_o  = 1'b0;
		mem_adr_o = '0;
		mem_dat_o = '0;
		case (state)
			ST_RQ0:  mem_adr_o = q_adr(cfg[Q_TXREQ], qptr[Q_TXREQ]);
			ST_RQ1:  mem_adr_o = q_adr(cfg[Q_TXREQ], qptr[Q_TXREQ]) | 28'h4;
			ST_CD0,
			ST_CD1:  mem_adr_o = cd_adr;
			ST_TXRD: mem_adr_o = {ck_adr[27:2], 2'h0};
			ST_CF0: begin
				mem_we_o  = 1'b1;
				mem_adr_o = q_adr(cfg[Q_CONF], qptr[Q_CONF]);
				mem_dat_o = {16'h0, tag};
			end
			ST_CF1: begin
				mem_we_o  = 1'b1;
				mem_adr_o = q_adr(cfg[Q_CONF], qptr[Q_CONF]) | 28'h4;
				mem_dat_o = 32'h80000000;
			end
			ST_PSP:  mem_adr_o = q_adr(cfg[Q_POOL], qptr[Q_POOL]);
			ST_RXWR: begin
				mem_we_o  = 1'b1;
				mem_adr_o = {rx_adr[27:2], 2'h0};
				mem_dat_o = rxf.data;
			end
			ST_ID0: begin
				mem_we_o  = 1'b1;
				mem_adr_o = q_adr(cfg[Q_IND], qptr[Q_IND]);
				mem_dat_o = {fr_end, 18'h0, rx_cnt};
			end
			ST_ID1: begin
				mem_we_o  = 1'b1;
				mem_adr_o = q_adr(cfg[Q_IND], qptr[Q_IND]) | 28'h4;
				mem_dat_o = {1'b1, 3'h0, rx_start};
			end
			default: mem_adr_o = '0;
		endcase
	end

	// sequencing; receive wins over transmit since its fifo can overflow upstream
	always_comb begin
		next_state    = state;
		next_qptr     = qptr;
		next_rq_w0    = rq_w0;
		next_word     = word;
		next_tag      = tag;
		next_cls      = cls;
		next_cd_adr   = cd_adr;
		next_ck_adr   = ck_adr;
		next_ck_len   = ck_len;
		next_ck_last  = ck_last;
		next_rx_adr   = rx_adr;
		next_rx_start = rx_start;
		next_rx_cnt   = rx_cnt;
		next_fr_end   = fr_end;
		next_buf_ok   = buf_ok;
		next_tx_byte  = tx_byte_o;
		next_tx_valid = tx_valid_o;
		next_tx_last  = tx_last_o;
		chunk_end     = 1'b0;
		rq_adv        = 1'b0;
		case (state)
			ST_IDLE: begin
				if (ctrl[CT_EN] && rxf_valid && buf_ok) begin
					next_state = ST_RXWR;
				end else if (ctrl[CT_EN] && rxf_valid && qptr[Q_POOL] != cfg[Q_POOL].lim) begin
					next_state = ST_PSP;
				end else if (ctrl[CT_EN] && qptr[Q_TXREQ] != cfg[Q_TXREQ].lim) begin
					next_state = ST_RQ0;
				end
			end
			ST_RQ0: if (done) begin
				next_rq_w0 = mem_dat_i;
				if (mem_dat_i[RQ_FIRST]) begin
					next_tag = mem_dat_i[15:0];
					next_cls = mem_dat_i[29:28];
				end
				next_state = ST_RQ1;
			end
			ST_RQ1: if (done) begin
				next_cd_adr = {mem_dat_i[27:3], 3'h0};
				next_state  = ST_CD0;
			end
			ST_CD0: if (done) begin
				next_ck_len  = mem_dat_i[12:0];
				next_ck_last = mem_dat_i[CK_LAST];
				next_cd_adr  = pg_inc(cd_adr, 12'h4);
				next_state   = ST_CD1;
			end
			ST_CD1: if (done) begin
				next_ck_adr = mem_dat_i[27:0];
				next_cd_adr = pg_inc(cd_adr, 12'h4);
				next_state  = ST_TXRD;
				chunk_end   = mem_dat_i[27:0] == 28'h0 ? 1'b0 : ck_len == 13'h0;
			end
			ST_TXRD: if (done) begin
				next_word     = mem_dat_i;
				next_tx_byte  = 8'(mem_dat_i >> {ck_adr[1:0], 3'h0});
				next_tx_valid = 1'b1;
				next_tx_last  = ck_last && rq_w0[RQ_LAST] && ck_len == 13'h1;
				next_state    = ST_TXOUT;
			end
			ST_TXOUT: if (tx_ready_i) begin
				next_ck_adr   = pg_inc(ck_adr, 12'h1);
				next_ck_len   = ck_len - 13'h1;
				next_tx_byte  = 8'(word >> {next_ck_adr[1:0], 3'h0});
				next_tx_last  = ck_last && rq_w0[RQ_LAST] && ck_len == 13'h2;
				if (ck_len == 13'h1) begin
					next_tx_valid = 1'b0;
					chunk_end     = 1'b1;
				end else if (next_ck_adr[1:0] == 2'h0) begin
					next_tx_valid = 1'b0;
					next_state    = ST_TXRD;
				end
			end
			ST_CF0: if (done) begin
				next_state = ST_CF1;
			end
			ST_CF1: if (done) begin
				next_qptr[Q_CONF] = q_inc(cfg[Q_CONF], qptr[Q_CONF]);
				next_state        = ST_IDLE;
			end
			ST_PSP: if (done) begin
				next_rx_adr       = mem_dat_i[27:0];
				next_rx_start     = mem_dat_i[27:0];
				next_rx_cnt       = '0;
				next_buf_ok       = 1'b1;
				next_qptr[Q_POOL] = q_inc(cfg[Q_POOL], qptr[Q_POOL]);
				next_state        = ST_RXWR;
			end
			ST_RXWR: if (done) begin
				next_rx_adr = pg_inc(rx_adr, 12'h4);
				next_rx_cnt = rx_cnt + 13'h4;
				next_fr_end = rxf.last;
				if (rx_adr[11:2] == 10'h3ff || (rxf.last && ctrl[CT_FPB])) begin
					next_buf_ok = 1'b0;
				end
				if (rxf.last || rx_adr[11:2] == 10'h3ff) begin
					next_state = ST_ID0;
				end
			end
			ST_ID0: if (done) begin
				next_state = ST_ID1;
			end
			ST_ID1: if (done) begin
				next_qptr[Q_IND] = q_inc(cfg[Q_IND], qptr[Q_IND]);
				next_rx_start    = rx_adr;
				next_rx_cnt      = '0;
				next_state       = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
		// end of a chunk: next descriptor, or the request object is consumed
		if (chunk_end) begin
			next_state = ST_CD0;
			if (ck_last) begin
				rq_adv              = 1'b1;
				next_qptr[Q_TXREQ] = q_inc(cfg[Q_TXREQ], qptr[Q_TXREQ]);
				next_state = rq_w0[RQ_LAST] && cls == CLS_TEND ? ST_CF0 : ST_IDLE;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
			qptr  <= '{default: '0};
			{rq_w0, word, tag, cls} <= '0;
			{cd_adr, ck_adr, ck_len, ck_last} <= '0;
			{rx_adr, rx_start, rx_cnt, fr_end, buf_ok} <= '0;
			{tx_byte_o, tx_valid_o, tx_last_o, gap} <= '0;
		end else begin
			state      <= next_state;
			qptr       <= next_qptr;
			rq_w0      <= next_rq_w0;
			word       <= next_word;
			tag        <= next_tag;
			cls        <= next_cls;
			cd_adr     <= next_cd_adr;
			ck_adr     <= next_ck_adr;
			ck_len     <= next_ck_len;
			ck_last    <= next_ck_last;
			rx_adr     <= next_rx_adr;
			rx_start   <= next_rx_start;
			rx_cnt     <= next_rx_cnt;
			fr_end     <= next_fr_end;
			buf_ok     <= next_buf_ok;
			tx_byte_o  <= next_tx_byte;
			tx_valid_o <= next_tx_valid;
			tx_last_o  <= next_tx_last;
			gap        <= done;
		end
	end

	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	chk_queue_region: assert property (mem_req_o && state == ST_PSP |->
		mem_adr_o[27:10] == (cfg[Q_POOL].big ? {cfg[Q_POOL].base[27:12], mem_adr_o[11:10]}
		: cfg[Q_POOL].base[27:10])) else $error("pool access left its region");
	chk_cdesc_wrap: assert property (state == ST_CD0 && done |=>
		cd_adr[27:12] == $past(cd_adr[27:12])) else $error("descriptor page changed");
	chk_rx_page: assert property (state == ST_RXWR && mem_req_o |->
		rx_adr[27:12] == rx_start[27:12]) else $error("receive write left page");
	chk_chunk_wrap: assert property (state == ST_TXOUT && tx_ready_i |=>
		ck_adr[27:12] == $past(ck_adr[27:12])) else $error("chunk page changed");
	chk_conf_tag: assert property (state == ST_CF0 && mem_req_o |->
		mem_we_o && mem_dat_o[15:0] == tag) else $error("confirm tag wrong");
	chk_ptr_adv: assert property (rq_adv |=>
		qptr[Q_TXREQ] != $past(qptr[Q_TXREQ])) else $error("request pointer stuck");
	chk_lim_gate: assert property (state == ST_IDLE && next_state == ST_RQ0 |->
		qptr[Q_TXREQ] != cfg[Q_TXREQ].lim) else $error("fetch past limit");
	chk_two_grants: assert property (state == ST_ID0 && done |=>
		!mem_req_o && state == ST_ID1) else $error("indicate words merged");
	chk_fpb_drop: assert property (rxf_pop && rxf.last && ctrl[CT_FPB] |=>
		!buf_ok && state == ST_ID0) else $error("buffer kept in frame mode");
	chk_loc_field: assert property (state == ST_ID1 && mem_req_o |->
		mem_dat_o[27:0] == rx_start) else $error("location field wrong");
	cov_confirm: cover property (state == ST_CF1 && done);
	cov_indicate: cover property (state == ST_ID1 && done && fr_end);
	cov_page_end: cover property (rxf_pop && rx_adr[11:2] == 10'h3ff);
	cov_rx_full: cover property (!rx_ready_o);
endmodule

// ---- verification/dqd_mem_model.sv ----
// shared descriptor and buffer memory model on the dma memory bus
`timescale 1ns/1ns
module dqd_mem_model (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// grant pace: low answers at once, high holds the grant back
	input  wire logic        slow_i,
	// memory bus
	input  wire logic        mem_req_i,
	output logic             mem_gnt_o,
	input  wire logic        mem_we_i,
	input  wire logic [27:0] mem_adr_i,
	input  wire logic [31:0] mem_dat_i,
	output logic [31:0]      mem_dat_o
);
	logic [31:0] mem [0:8191];
	logic [27:0] log_adr [$];
	logic [31:0] log_dat [$];
	logic [1:0]  wait_cnt;
	logic        gnt_q;
	logic [31:0] last_q;
	int          n_err = 0;
	// --------------------------------------------------------------
	// grant and read data
	// --------------------------------------------------------------
	// slow grants stretch every request, so a design that lets go early is caught
	assign mem_gnt_o = mem_req_i && (!slow_i || wait_cnt == 2'h3);
	// outside a read grant the lines carry the inverse of the last word, never a stale match
	assign mem_dat_o = (mem_gnt_o && !mem_we_i) ? mem[mem_adr_i[14:2]] : ~last_q;
	// one word per grant; writes are logged in arrival order
	// plain always: the bench also pokes the array and empties the logs between tests
	always @(posedge clk_i) begin
		if (rst_i) begin
			wait_cnt <= 2'h0;
			gnt_q    <= 1'b0;
			last_q   <= 32'h0;
		end else begin
			gnt_q    <= mem_gnt_o;
			wait_cnt <= (mem_req_i && !mem_gnt_o) ? wait_cnt + 2'h1 : 2'h0;
			// a request straight after a grant means two words shared one cycle
			if (gnt_q && mem_req_i)
				n_err <= n_err + 1;
			if (mem_gnt_o) begin
				last_q <= mem_we_i ? mem_dat_i : mem_dat_o;
				if (mem_we_i) begin
					mem[mem_adr_i[14:2]] <= mem_dat_i;
					log_adr.push_back(mem_adr_i);
					log_dat.push_back(mem_dat_i);
				end
			end
		end
	end
endmodule

// ---- verification/testbench.sv ----
// self-checking testbench of the descriptor queue dma
`timescale 1ns/1ns
module testbench;
	import dqd_pkg::*;
	logic              clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, slow;
	logic [7:0]        wb_adr_i, tx_byte_o;
	logic [3:0]        wb_sel_i;
	logic [31:0]       wb_dat_i, wb_dat_o, mem_dat_o, mem_dat_i, q;
	logic              mem_req_o, mem_gnt_i, mem_we_o, tx_valid_o, tx_last_o, tx_ready_i;
	logic [27:0]       mem_adr_o;
	dqd_rxw_t          rx_word_i;
	logic              rx_valid_i, rx_ready_o;
	int                n_fail = 0;
	int                cmp_count = 0;
	int                nb;
	logic [8:0]        got [0:4];
	// expected writes of the receive run: address, data pairs
	localparam logic [31:0] RX_EXP [24] = '{32'h4ff0, 32'ha0000000, 32'h4ff4, 32'ha0000001,
		32'h4ff8, 32'ha0000002, 32'h4ffc, 32'ha0000003, 32'h1c00, 32'h10, 32'h1c04,
		32'h80004ff0, 32'h6000, 32'ha0000004, 32'h6004, 32'ha0000005, 32'h6008, 32'ha0000006,
		32'h600c, 32'ha0000007, 32'h1c08, 32'h80000010, 32'h1c0c, 32'h80006000};
	// frame-per-buffer run: one frame into the held buffer, the next into a fresh one
	localparam logic [31:0] RX_FPB [12] = '{32'h6010, 32'hb0000000, 32'h1c10, 32'h80000004,
		32'h1c14, 32'h80006010, 32'h7000, 32'hb0000001, 32'h1c18, 32'h80000004,
		32'h1c1c, 32'h80007000};

	dqd_dma #(.FIFO_DEPTH(8)) DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .mem_req_o, .mem_gnt_i, .mem_we_o,
		.mem_adr_o, .mem_dat_o, .mem_dat_i, .tx_byte_o, .tx_valid_o, .tx_last_o, .tx_ready_i,
		.rx_word_i, .rx_valid_i, .rx_ready_o);
	dqd_mem_model mem_model (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
		.mem_req_i(mem_req_o), .mem_gnt_o(mem_gnt_i), .mem_we_i(mem_we_o),
		.mem_adr_i(mem_adr_o), .mem_dat_i(mem_dat_o), .mem_dat_o(mem_dat_i));

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	// --------------------------------------------------------------
	// shared tasks
	// --------------------------------------------------------------
	task automatic results();
		$display("checks %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic check(input logic [31:0] g, input logic [31:0] e, input string what);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("Error at %0t: %s got %h expected %h", $time, what, g, e);
		end
	endtask
	// classic wishbone cycle: held until ack is sampled, released at that edge
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, a, d};
		for (i = 0; i < 50; i++) begin
			@(posedge clk_i);
			if (wb_ack_o === 1'b1)
				break;
		end
		q = wb_dat_o;
		{wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
		if (i >= 50) begin
			check(1'b0, 1'b1, "wishbone ack timeout");
			results();
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string what);
		wb(1'b0, a, 32'h0);
		check(q, e, what);
	endtask
	task automatic poke(input logic [27:0] a, input logic [31:0] d);
		mem_model.mem[a[14:2]] = d;
	endtask
	task automatic rx_push(input logic [31:0] d, input logic last);
		int i;
		@(posedge clk_i);
		rx_word_i  <= '{d, last};
		rx_valid_i <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk_i);
			if (rx_ready_o === 1'b1)
				break;
		end
		rx_valid_i <= 1'b0;
		if (i >= 50) begin
			check(1'b0, 1'b1, "receive ready timeout");
			results();
		end
	endtask
	task automatic wait_log(input int n);
		int i;
		for (i = 0; i < 3000 && mem_model.log_adr.size() < n; i++)
			@(posedge clk_i);
		if (i >= 3000) begin
			check(1'b0, 1'b1, "memory write timeout");
			results();
		end
	endtask
	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial begin
		{wb_cyc_i, wb_stb_i, wb_we_i, rx_valid_i, tx_ready_i, slow} = 6'h0;
		{wb_adr_i, wb_dat_i, rx_word_i} = '0;
		wb_sel_i = 4'hf;
		rst_i    = 1'b1;
		// host side: pool buffers 16-byte aligned, chunk array 8-byte aligned
		poke(28'h1800, 32'h4ff0);
		poke(28'h1808, 32'h6000);
		poke(28'h1810, 32'h7000);
		poke(28'h5000, 32'h5e5e5e5e);
		poke(28'h1000, 32'hd0001234);
		poke(28'h1004, 32'h2000);
		poke(28'h2000, 32'h80000005);
		poke(28'h2004, 32'h3ffe);
		poke(28'h3ffc, 32'h77777777);
		poke(28'h3000, 32'h55555555);
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		// reset values and an unmapped place
		rd_chk(OFF_CTRL, 32'h0, "ctrl after reset");
		rd_chk(8'h08, 32'h0, "request pointer after reset");
		wb(1'b1, 8'h80, 32'hffffffff);
		rd_chk(8'h80, 32'h0, "unmapped read");
		$display("test reset done");
		// receive: fifo fills while disabled, frame spans two buffers cut at 4 kb
		slow <= 1'b1;
		wb(1'b1, 8'h20, 32'h1800);
		wb(1'b1, 8'h24, 32'h10);
		wb(1'b1, 8'h30, 32'h1c00);
		wb(1'b1, 8'h34, 32'h10);
		for (int k = 0; k < 8; k++)
			rx_push(32'ha0000000 + k, k == 7);
		@(posedge clk_i);
		check(rx_ready_o, 1'b0, "fifo full refusal");
		wb(1'b1, OFF_CTRL, 32'h1);
		wait_log(12);
		for (int k = 0; k < 12; k++) begin
			check({4'h0, mem_model.log_adr[k]}, RX_EXP[2*k], "rx write address");
			check(mem_model.log_dat[k], RX_EXP[2*k+1], "rx write data");
		end
		check(mem_model.mem[28'h1c04 >> 2] & 32'h80000000, 32'h80000000, "probe word1");
		check(mem_model.mem[28'h5000 >> 2], 32'h5e5e5e5e, "beyond page");
		check(mem_model.log_dat[5] & {4'h0, PAGE_SEL}, 32'h4000, "page of buffer");
		rd_chk(8'h28, 32'h10, "pool pointer");
		rd_chk(8'h38, 32'h10, "indicate pointer");
		$display("test receive done");
		// transmit: limit written while running, chunk wraps inside its page
		slow <= 1'b0;
		mem_model.log_adr.delete();
		mem_model.log_dat.delete();
		wb(1'b1, 8'h10, 32'h1400);
		wb(1'b1, 8'h14, 32'h8);
		wb(1'b1, 8'h00, 32'h1000);
		wb(1'b1, 8'h04, 32'h8);
		nb = 0;
		for (int c = 0; c < 600 && (nb < 5 || mem_model.log_adr.size() < 2); c++) begin
			@(posedge clk_i);
			if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1 && nb < 5) begin
				got[nb] = {tx_last_o, tx_byte_o};
				nb++;
			end
			tx_ready_i <= ~tx_ready_i;
		end
		if (nb < 5 || mem_model.log_adr.size() < 2)
			check(1'b0, 1'b1, "transmit timeout");
		for (int k = 0; k < 5; k++)
			check(got[k], {k == 4, (k < 2) ? 8'h77 : 8'h55}, "tx byte");
		check(mem_model.log_adr.size(), 2, "confirm word count");
		check({4'h0, mem_model.log_adr[0]}, 32'h1400, "confirm word0 address");
		check(mem_model.log_dat[0], 32'h1234, "confirm tag");
		check({4'h0, mem_model.log_adr[1]}, 32'h1404, "confirm word1 address");
		check(mem_model.log_dat[1], 32'h80000000, "confirm word1");
		check(mem_model.n_err, 0, "request gap after grant");
		rd_chk(8'h08, 32'h8, "request pointer advanced");
		rd_chk(8'h18, 32'h8, "confirm pointer");
		$display("test transmit done");
		// frame-per-buffer: the held buffer ends with its frame, the next frame takes a new one
		mem_model.log_adr.delete();
		mem_model.log_dat.delete();
		wb(1'b1, 8'h24, 32'h18);
		wb(1'b1, 8'h34, 32'h20);
		wb(1'b1, OFF_CTRL, 32'h3);
		rx_push(32'hb0000000, 1'b1);
		rx_push(32'hb0000001, 1'b1);
		wait_log(6);
		for (int k = 0; k < 6; k++) begin
			check({4'h0, mem_model.log_adr[k]}, RX_FPB[2*k], "fpb write address");
			check(mem_model.log_dat[k], RX_FPB[2*k+1], "fpb write data");
		end
		rd_chk(8'h28, 32'h18, "pool pointer after frames");
		$display("test frame per buffer done");
		results();
	end
endmodule
